// >>> design/srap_device.sv
// What this block does
// - four scratch bytes at 0x06..0x09
// - register contents shift out while data shifts in
// - select active low, output floats when high
// - host idles clock low
// - sample on falling, change on rising
// - 8-bit registers, 7-bit addresses
// - address byte with read flag, then data
// - read flag set leaves registers unchanged
// - 24/32-bit frames auto-increment address
// - addressed register contents shifted out
// - bad bit count aborts write, sets fault
// - illegal frames discarded, registers untouched
// - frames before ready timeout raise fault
// - host keeps write gap after every frame
// - address wraps to 0x00 without fault
// - 128 registers, 0x00 to 0x7F
`timescale 1ns/1ps
`default_nettype none
module srap_device (
    input wire logic clk,
    input wire logic arst_n,
    srap_if.device link,
    output logic serial_fault_flag,
    output logic serial_fault_irq,
    output logic ready,
    input wire logic fault_clear
);
    import srap_pkg::*;

    ////////////////////////////////////////////////////////////////
    // link domain: shift, capture bytes, count bits
    logic [7:0] rx_q;
    logic [5:0] cnt_q;
    logic [6:0] addr_q;
    logic rd_q;
    logic [7:0] tx_q;
    logic [7:0] b1_q, b2_q, b3_q;
    logic [7:0] regs_view [REG_COUNT];
    logic [7:0] rx_d;
    logic [6:0] cur_addr;

    assign rx_d = {rx_q[6:0], link.sdi}; // msb first

    // current register index, wrapping past 0x7F
    always_comb begin
        cur_addr = addr_q + 7'(cnt_q[5:3] - 3'd1);
    end

    // sample on falling edge; frame starts with select low
    always_ff @(negedge link.sclk or posedge link.target_select_n) begin
        if (link.target_select_n) begin
            cnt_q <= 6'h00;
            rx_q <= 8'h00;
        end else begin
            rx_q <= rx_d;
            if (cnt_q != 6'h3F) cnt_q <= cnt_q + 6'h01;
        end
    end

    // latch address byte and data bytes at byte boundaries
    always_ff @(negedge link.sclk or negedge arst_n) begin
        if (!arst_n) begin
            addr_q <= 7'h00;
            rd_q <= 1'b1;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            b3_q <= 8'h00;
        end else if (!link.target_select_n) begin
            unique case (cnt_q)
                6'h00: rd_q <= 1'b0; // a frame cut before the flag counts as a write
                6'h07: begin
                    addr_q <= rx_d[7:1];
                    rd_q <= rx_d[0];
                end
                6'h0F: b1_q <= rx_d;
                6'h17: b2_q <= rx_d;
                6'h1F: b3_q <= rx_d;
                default: ;
            endcase
        end
    end

    // shift register contents out on rising edge
    always_ff @(posedge link.sclk or posedge link.target_select_n) begin
        if (link.target_select_n) begin
            tx_q <= 8'h00;
        end else if (cnt_q[2:0] == 3'd0 && cnt_q != 6'h00) begin
            tx_q <= regs_view[cur_addr];
        end else begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // output floats outside frames
    assign link.sdo_o = tx_q[7];
    assign link.sdo_oe_n = link.target_select_n;

    ////////////////////////////////////////////////////////////////
    // end-of-frame event crossing: toggle on select rising edge
    // captured bytes and count stand still once sclk stops, so the clk side reads them
    // only after the synchronised toggle; the host gap keeps the next frame away meanwhile
    // hazard: the hold flop and the count reset share the select edge, keep their skew small
    logic frame_tgl_q;
    logic [5:0] cnt_hold_q;
    always_ff @(posedge link.target_select_n or negedge arst_n) begin
        if (!arst_n) begin
            frame_tgl_q <= 1'b0;
            cnt_hold_q <= 6'h00;
        end else begin
            frame_tgl_q <= ~frame_tgl_q;
            cnt_hold_q <= cnt_q;
        end
    end

    logic [2:0] tgl_sync_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) tgl_sync_q <= 3'b000;
        else tgl_sync_q <= {tgl_sync_q[1:0], frame_tgl_q};
    end
    logic frame_done;
    assign frame_done = tgl_sync_q[2] ^ tgl_sync_q[1];

    ////////////////////////////////////////////////////////////////
    // ready timeout after reset
    // frames ending before ready are flagged, reads included; writes are refused, reads still shift out register contents
    logic [$clog2(READY_TIMEOUT_CYC+1)-1:0] rdy_cnt_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_cnt_q <= '0;
            ready <= 1'b0;
        end else if (!ready) begin
            rdy_cnt_q <= rdy_cnt_q + 1'b1;
            if (rdy_cnt_q == ($bits(rdy_cnt_q))'(READY_TIMEOUT_CYC - 1)) ready <= 1'b1;
        end
    end

    // frame decision: legal length, write or read
    logic len_ok, do_write, fault_ev;
    logic [1:0] nbytes;
    always_comb begin
        len_ok = (cnt_hold_q == BITS_16) || (cnt_hold_q == BITS_24) || (cnt_hold_q == BITS_32);
        nbytes = 2'(cnt_hold_q[5:3] - 3'd1);
        do_write = frame_done && ready && !rd_q && len_ok;
        fault_ev = frame_done && cnt_hold_q != 6'h00 && (!ready || (!rd_q && !len_ok));
    end

    ////////////////////////////////////////////////////////////////
    // register space; only implemented bytes store, others tolerated
    logic [7:0] irq_en_q;
    logic [7:0] scratch_q [4];
    logic [7:0] wdata [3];
    assign wdata[0] = b1_q;
    assign wdata[1] = b2_q;
    assign wdata[2] = b3_q;

    // target of the k-th data byte, wrapping past 0x7F to 0x00
    function automatic logic [6:0] slot_addr(input logic [6:0] base, input int k);
        return base + 7'(k);
    endfunction : slot_addr

    // true for the four user scratch addresses
    function automatic logic is_scratch(input logic [6:0] a);
        return (a >= ADDR_SCRATCH0) && (a <= ADDR_SCRATCH3);
    endfunction : is_scratch

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_en_q <= IRQ_EN_RESET;
            for (int s = 0; s < 4; s++) scratch_q[s] <= SCRATCH_RESET;
        end else if (do_write) begin
            for (int k = 0; k < 3; k++) begin
                if (2'(k) < nbytes) begin
                    if (slot_addr(addr_q, k) == ADDR_IRQ_EN) irq_en_q <= wdata[k] & READ_ONLY_MASK;
                    if (is_scratch(slot_addr(addr_q, k))) begin
                        scratch_q[2'(slot_addr(addr_q, k) - ADDR_SCRATCH0)] <= wdata[k];
                    end
                end
            end
        end
    end

    // read view; the link samples this mid-frame, bytes are quasi-static between writes
    // limitation: a write landing on the rising edge that loads the same byte into the shifter may return a mix of old and new
    generate
        for (genvar g = 0; g < REG_COUNT; g++) begin : g_view
            if (g == ADDR_IRQ_EN) assign regs_view[g] = irq_en_q;
            else if (g >= ADDR_SCRATCH0 && g <= ADDR_SCRATCH3) assign regs_view[g] = scratch_q[g - ADDR_SCRATCH0];
            else assign regs_view[g] = 8'h00;
        end
    endgenerate

    // next fault state; a new fault beats a clear in the same cycle
    logic fault_d;
    always_comb begin
        fault_d = serial_fault_flag;
        if (fault_clear) fault_d = 1'b0;
        if (fault_ev) fault_d = 1'b1;
    end

    // sticky fault flag, held until the clear input
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) serial_fault_flag <= 1'b0;
        else serial_fault_flag <= fault_d;
    end

    // interrupt follows the next flag state, so it never outlives a clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) serial_fault_irq <= 1'b0;
        else serial_fault_irq <= fault_d & irq_en_q[IRQ_EN_FAULT_BIT];
    end
endmodule : srap_device
`default_nettype wire

// >>> design/srap_pkg.sv
package srap_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 128;
    localparam logic [6:0] ADDR_IRQ_EN = 7'h04;
    localparam logic [6:0] ADDR_SCRATCH0 = 7'h06;
    localparam logic [6:0] ADDR_SCRATCH3 = 7'h09;
    localparam int IRQ_EN_FAULT_BIT = 1;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [7:0] READ_ONLY_MASK = 8'h06;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_24 = 6'h18;
    localparam logic [5:0] BITS_32 = 6'h20;
    localparam int READY_TIMEOUT_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int READY_TIMEOUT_CYC = (READY_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOST_DIV = 4;
    localparam int WRITE_GAP_NS = 100;
    localparam int WRITE_GAP_CYC = (WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : srap_pkg

// >>> design/srap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface srap_if;
    logic sclk;
    logic target_select_n;
    logic sdi;
    logic sdo_o;
    logic sdo_oe_n;
    modport device (input sclk, input target_select_n, input sdi, output sdo_o, output sdo_oe_n);
    modport host (output sclk, output target_select_n, output sdi, input sdo_o, input sdo_oe_n);
endinterface : srap_if
`default_nettype wire

// >>> design/srap_host.sv
`timescale 1ns/1ps
`default_nettype none
module srap_host (
    input wire logic clk,
    input wire logic arst_n,
    srap_if.host link,
    input wire logic start,
    input wire logic [5:0] nbits,
    input wire logic [31:0] tx_word,
    output logic busy,
    output logic done,
    output logic [31:0] rx_word
);
    import srap_pkg::*;

    typedef enum {IDLE, SHIFT, GAP} srap_hstate_t;
    srap_hstate_t st_q;
    logic [5:0] left_q;
    logic [31:0] sh_q;
    logic [$clog2(HOST_DIV)-1:0] div_q;
    logic [$clog2(WRITE_GAP_CYC+1)-1:0] gap_q;
    logic sdo_s1_q, sdo_s2_q;

    // two-flop sync of returned data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sdo_s1_q <= 1'b0;
            sdo_s2_q <= 1'b0;
        end else begin
            sdo_s1_q <= link.sdo_o;
            sdo_s2_q <= sdo_s1_q;
        end
    end

    // clock idles low; data set on rise, sampled on fall
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= IDLE;
            link.sclk <= 1'b0;
            link.target_select_n <= 1'b1;
            link.sdi <= 1'b0;
            left_q <= 6'h00;
            sh_q <= 32'h0;
            div_q <= '0;
            gap_q <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            rx_word <= 32'h0;
        end else begin
            done <= 1'b0;
            unique case (st_q)
                IDLE: if (start) begin
                    st_q <= SHIFT;
                    busy <= 1'b1;
                    left_q <= nbits;
                    sh_q <= tx_word;
                    rx_word <= 32'h0;
                    link.target_select_n <= 1'b0;
                    div_q <= '0;
                end
                SHIFT: begin
                    div_q <= div_q + 1'b1;
                    if (div_q == '0) begin
                        link.sclk <= 1'b1; // drive next bit msb first
                        link.sdi <= sh_q[31];
                        sh_q <= {sh_q[30:0], 1'b0};
                    end else if (div_q == ($bits(div_q))'(HOST_DIV / 2)) begin
                        link.sclk <= 1'b0;
                    end else if (div_q == ($bits(div_q))'(HOST_DIV - 1)) begin
                        // sdo comes through two flops, so the bit standing at the fall arrives now
                        rx_word <= {rx_word[30:0], sdo_s2_q};
                        left_q <= left_q - 6'h01;
                        if (left_q == 6'h01) begin
                            st_q <= GAP;
                            gap_q <= '0;
                        end
                    end
                end
                GAP: begin
                    link.target_select_n <= 1'b1;
                    gap_q <= gap_q + 1'b1;
                    if (gap_q == ($bits(gap_q))'(WRITE_GAP_CYC)) begin // spacing between frames
                        st_q <= IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule : srap_host
`default_nettype wire

// >>> tb/srap_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module srap_asserts
    import srap_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic target_select_n,
    input wire logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe_n,
    input wire logic serial_fault_flag,
    input wire logic serial_fault_irq,
    input wire logic ready,
    input wire logic fault_clear
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic [7:0] since_q;
    ////////////////////////////////////////////////////////////////////////////
    // cycles since reset release, saturating so it never wraps
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) since_q <= 8'h00;
        else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
    end
    // one serial clock pulse: two cycles high, then low
    sequence sclk_pulse;
        sclk ##1 sclk ##1 !sclk;
    endsequence
    sequence sel_idle;
        target_select_n && $past(target_select_n);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_sdo_floats: assert property (sel_idle |-> sdo_oe_n && !sdo_o)
        else $error("sdo driven while deselected");
    a_sdo_driven: assert property ($fell(target_select_n) |-> ##[0:3] !sdo_oe_n) else $error("sdo not driven");
    a_clk_idle_low: assert property (sel_idle |-> !sclk) else $error("sclk high while idle");
    a_sdi_on_rise: assert property (!target_select_n && $past(!target_select_n) && $changed(sdi) |-> $rose(sclk))
        else $error("sdi moved off the rising edge");
    a_sclk_shape: assert property ($rose(sclk) |-> sclk_pulse) else $error("sclk pulse malformed");
    a_ready_early: assert property (since_q < READY_TIMEOUT_CYC - 2 |-> !ready) else $error("ready too early");
    a_ready_late: assert property (since_q > READY_TIMEOUT_CYC + 2 |-> ready) else $error("ready too late");
    a_write_gap: assert property ($rose(target_select_n) |-> target_select_n [*8]) else $error("gap too short");
    a_fault_sticky: assert property (serial_fault_flag && !fault_clear |=> serial_fault_flag)
        else $error("fault flag dropped");
    a_irq_has_flag: assert property (serial_fault_irq |-> serial_fault_flag) else $error("irq without flag");
endmodule : srap_asserts
`default_nettype wire

// >>> tb/spi_register_access_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_register_access_port_test;
    import srap_pkg::*;
    typedef struct {int kind; logic [7:0] exp;} srap_note_t;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    logic fault_clear = 1'b0;
    logic [5:0] nbits = 6'h10;
    logic [31:0] tx_word = 32'h0;
    logic busy, done, flag, irq, ready;
    logic [31:0] rx_word;
    logic [7:0] d0, d1, d2, d3;
    int fails = 0;
    int check_count = 0;
    srap_note_t notes[$];
    srap_note_t n;
    srap_if srap_if_inst ();
    srap_device srap_device_inst (.clk(clk), .arst_n(arst_n), .link(srap_if_inst), .serial_fault_flag(flag),
        .serial_fault_irq(irq), .ready(ready), .fault_clear(fault_clear));
    srap_host srap_host_inst (.clk(clk), .arst_n(arst_n), .link(srap_if_inst), .start(start), .nbits(nbits),
        .tx_word(tx_word), .busy(busy), .done(done), .rx_word(rx_word));
    srap_asserts srap_asserts_inst (.clk(clk), .arst_n(arst_n), .sclk(srap_if_inst.sclk),
        .target_select_n(srap_if_inst.target_select_n), .sdi(srap_if_inst.sdi), .sdo_o(srap_if_inst.sdo_o),
        .sdo_oe_n(srap_if_inst.sdo_oe_n), .serial_fault_flag(flag), .serial_fault_irq(irq), .ready(ready),
        .fault_clear(fault_clear));
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // kind 0 read byte, 1 fault flag, 2 irq; note is logged before the frame starts
    task automatic frame(input logic [5:0] len, input logic [31:0] w, input int kind, input logic [7:0] exp);
        int i;
        notes.push_back('{kind, exp});
        @(posedge clk);
        #1 nbits = len;
        tx_word = w;
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        for (i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk);
        if (done !== 1'b1) begin
            fails++;
            give_verdict();
        end
        @(posedge clk);
    endtask : frame
    task automatic clear_fault;
        @(posedge clk);
        #1 fault_clear = 1'b1;
        @(posedge clk);
        #1 fault_clear = 1'b0;
    endtask : clear_fault
    ////////////////////////////////////////////////////////////////////////////
    // watcher: done carries the settled result of the frame just ended
    always @(posedge clk) begin
        if (done === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            if (n.kind == 0) check(rx_word[7:0], n.exp);
            else if (n.kind == 1) check({7'h00, flag}, n.exp);
            else check({7'h00, irq}, n.exp);
        end
    end
    // watchdog: whole run is some 1500 cycles
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(53));
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        d3 = 8'($urandom);
        repeat (10) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge clk);
        frame(6'h10, {7'h06, 1'b0, 8'hA5, 16'h0}, 1, 8'h01);
        clear_fault();
        for (int i = 0; i < 300 && ready !== 1'b1; i++) @(posedge clk);
        if (ready !== 1'b1) begin
            fails++;
            give_verdict();
        end
        frame(6'h10, {ADDR_SCRATCH0, 1'b1, 8'h00, 16'h0}, 0, SCRATCH_RESET);
        frame(6'h10, {ADDR_SCRATCH0, 1'b0, d0, 16'h0}, 1, 8'h00);
        frame(6'h10, {ADDR_SCRATCH0, 1'b1, ~d0, 16'h0}, 0, d0);
        frame(6'h10, {ADDR_SCRATCH0, 1'b1, 8'h00, 16'h0}, 0, d0);
        frame(6'h20, {7'h07, 1'b0, d1, d2, d3}, 1, 8'h00);
        frame(6'h10, {7'h07, 1'b1, 16'h0, 8'h00}, 0, d1);
        frame(6'h10, {7'h08, 1'b1, 16'h0, 8'h00}, 0, d2);
        frame(6'h10, {ADDR_SCRATCH3, 1'b1, 16'h0, 8'h00}, 0, d3);
        frame(6'h14, {ADDR_SCRATCH0, 1'b0, ~d0, 16'h0}, 1, 8'h01);
        frame(6'h10, {ADDR_SCRATCH0, 1'b1, 16'h0, 8'h00}, 0, d0);
        clear_fault();
        frame(6'h18, {7'h7F, 1'b0, 8'h3C, 8'hC3, 8'h00}, 1, 8'h00);
        frame(6'h10, {7'h0A, 1'b1, 16'h0, 8'h00}, 0, 8'h00);
        frame(6'h10, {ADDR_IRQ_EN, 1'b1, 16'h0, 8'h00}, 0, IRQ_EN_RESET);
        frame(6'h10, {ADDR_IRQ_EN, 1'b0, 8'h02, 16'h0}, 2, 8'h00);
        frame(6'h0C, {ADDR_SCRATCH0, 1'b0, 8'h00, 16'h0}, 2, 8'h01);
        frame(6'h10, {ADDR_IRQ_EN, 1'b1, 16'h0, 8'h00}, 0, 8'h02);
        repeat (5) @(posedge clk);
        give_verdict();
    end
endmodule : spi_register_access_port_test
`default_nettype wire
